// File: rtl/d_access_pkg.sv
package d_access_pkg;
    // APB register map, byte addresses
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] COLL_OFFSET = 8'h08;
    // Control register fields
    localparam int CTRL_CLASS_LSB = 0;
    localparam int CTRL_ENABLE_BIT = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
    // Status register fields
    localparam int STAT_GRANT_BIT = 0;
    localparam int STAT_SEND_BIT = 1;
    localparam int STAT_COUNT_LSB = 8;
    // Ones counted per priority class; the next echoed one after the count grants
    localparam logic [3:0] CLASS0_ONES = 4'h8;
    localparam logic [3:0] CLASS1_ONES = 4'h9;
    localparam logic [3:0] CLASS2_ONES = 4'ha;
    localparam logic [3:0] CLASS3_ONES = 4'hb;
    localparam int COLL_CNT_W = 8;

    typedef enum logic [1:0] {
        LINK_MONITOR = 2'b00,
        LINK_SEND = 2'b01,
        LINK_BACKOFF = 2'b10
    } link_state_e;

    typedef struct packed {
        logic enable;
        logic [1:0] prio_class;
    } access_cfg_s;

    typedef struct packed {
        logic frame_sync;
        logic d_slot;
        logic echo_slot;
        logic echo_bit;
    } link_in_s;
endpackage

// File: rtl/d_channel_access_arbiter.sv
`timescale 1ns/100ps
module d_channel_access_arbiter
    import d_access_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic link_clk_i,
    input wire logic frame_sync_i,
    input wire logic d_slot_i,
    input wire logic echo_slot_i,
    input wire logic echo_bit_i,
    input wire logic interchip_serial_data_in_i,
    input wire logic access_request_in_i,
    output logic access_grant_out_o,
    output logic loop_d_bit_o
);
    // Elaboration check: the decoder reads eight address bits
    if (ADDR_W < 8)
    begin
        $error("ADDR_W must cover the register map");
    end

    // Needed run of ones for a class
    function automatic logic [3:0] class_ones(input logic [1:0] c);
        logic [3:0] n;
        n = CLASS0_ONES;
        unique case (c)
            2'b00: n = CLASS0_ONES;
            2'b01: n = CLASS1_ONES;
            2'b10: n = CLASS2_ONES;
            2'b11: n = CLASS3_ONES;
        endcase
        return n;
    endfunction

    // ---------------- Core domain: APB slave ----------------
    logic [31:0] ctrl_q, ctrl_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [COLL_CNT_W-1:0] coll_cnt_q, coll_cnt_d;
    logic grant_s1_q, grant_s2_q;
    logic send_s1_q, send_s2_q;
    logic coll_t1_q, coll_t2_q, coll_t3_q;
    logic grant_q, grant_d;
    logic send_flag_q, send_flag_d;
    logic coll_tog_q, coll_tog_d;
    logic access;
    logic [7:0] addr8;

    assign access = psel_i && penable_i && !pready_q;
    assign addr8 = paddr_i[7:0];

    // Decode and answer; one wait state keeps every bus output registered
    always_comb
    begin
        ctrl_d = ctrl_q;
        prdata_d = prdata_q;
        pready_d = access;
        pslverr_d = 1'b0;
        coll_cnt_d = coll_cnt_q;
        if (access)
        begin
            prdata_d = 32'h0000_0000;
            unique case (addr8)
                CTRL_OFFSET:
                begin
                    if (pwrite_i)
                    begin
                        ctrl_d = {29'h0, pwdata_i[2:0]};
                    end
                    else
                    begin
                        prdata_d = ctrl_q;
                    end
                end
                STATUS_OFFSET:
                begin
                    prdata_d[STAT_GRANT_BIT] = grant_s2_q;
                    prdata_d[STAT_SEND_BIT] = send_s2_q;
                    pslverr_d = pwrite_i; // Read only
                end
                COLL_OFFSET:
                begin
                    prdata_d[COLL_CNT_W-1:0] = coll_cnt_q;
                    if (pwrite_i)
                    begin
                        coll_cnt_d = '0; // Write clears
                    end
                end
                default: pslverr_d = 1'b1;
            endcase
        end
        // A collision in the clearing cycle still counts, so none is lost
        if (coll_t2_q != coll_t3_q)
        begin
            coll_cnt_d = coll_cnt_d + 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ctrl_q <= CTRL_RESET;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            coll_cnt_q <= '0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            coll_cnt_q <= coll_cnt_d;
        end
    end

    // Link status into core clock: levels by two flops, collisions by toggle
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            grant_s1_q <= 1'b0;
            grant_s2_q <= 1'b0;
            send_s1_q <= 1'b0;
            send_s2_q <= 1'b0;
            coll_t1_q <= 1'b0;
            coll_t2_q <= 1'b0;
            coll_t3_q <= 1'b0;
        end
        else
        begin
            grant_s1_q <= grant_q;
            grant_s2_q <= grant_s1_q;
            send_s1_q <= send_flag_q;
            send_s2_q <= send_s1_q;
            coll_t1_q <= coll_tog_q;
            coll_t2_q <= coll_t1_q;
            coll_t3_q <= coll_t2_q;
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;

    // ---------------- Link domain ----------------
    access_cfg_s cfg_s1_q, cfg_s2_q;
    link_in_s lin;
    logic req_s1_q, req_s2_q, req_prev_q;
    logic [3:0] ones_q, ones_d;
    logic sent_one_q, sent_one_d;
    logic loop_q, loop_d;
    link_state_e state_q, state_d;
    logic req_rise;

    // Link strobes share the link clock, so they need no synchroniser
    assign lin = '{frame_sync: frame_sync_i, d_slot: d_slot_i,
                   echo_slot: echo_slot_i, echo_bit: echo_bit_i};

    // Request pin and quasi-static control; change class only while idle
    always_ff @(posedge link_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            cfg_s1_q <= '0;
            cfg_s2_q <= '0;
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_prev_q <= 1'b0;
        end
        else
        begin
            cfg_s1_q <= '{enable: ctrl_q[CTRL_ENABLE_BIT],
                          prio_class: ctrl_q[CTRL_CLASS_LSB+:2]};
            cfg_s2_q <= cfg_s1_q;
            req_s1_q <= access_request_in_i;
            req_s2_q <= req_s1_q;
            req_prev_q <= req_s2_q;
        end
    end

    assign req_rise = req_s2_q && !req_prev_q;

    // Arbitration: count echoed ones, send, and back off on collision
    always_comb
    begin
        state_d = state_q;
        ones_d = ones_q;
        grant_d = grant_q;
        sent_one_d = sent_one_q;
        loop_d = loop_q;
        coll_tog_d = coll_tog_q;
        unique case (state_q)
            LINK_MONITOR, LINK_BACKOFF:
            begin
                loop_d = 1'b1;
                if (lin.echo_slot)
                begin
                    if (!lin.echo_bit)
                    begin
                        ones_d = 4'h0;
                        grant_d = 1'b0;
                    end
                    else if (ones_q < class_ones(cfg_s2_q.prio_class))
                    begin
                        ones_d = ones_q + 4'h1;
                    end
                    else
                    begin
                        grant_d = cfg_s2_q.enable;
                    end
                end
                if (state_q == LINK_BACKOFF && !req_s2_q)
                begin
                    state_d = LINK_MONITOR;
                end
                else if (state_q == LINK_MONITOR && req_s2_q && grant_d
                         && (req_rise || ones_q >= class_ones(cfg_s2_q.prio_class)))
                begin
                    state_d = LINK_SEND;
                end
            end
            LINK_SEND:
            begin
                if (!req_s2_q || !cfg_s2_q.enable)
                begin
                    state_d = LINK_MONITOR;
                    loop_d = 1'b1;
                    // Grant stays while enabled, so the next request sends at once
                    grant_d = grant_q && cfg_s2_q.enable;
                end
                else
                begin
                    if (lin.d_slot)
                    begin
                        loop_d = interchip_serial_data_in_i;
                        sent_one_d = interchip_serial_data_in_i;
                    end
                    if (lin.echo_slot && sent_one_q && !lin.echo_bit)
                    begin
                        state_d = LINK_BACKOFF;
                        grant_d = 1'b0;
                        loop_d = 1'b1;
                        ones_d = 4'h0;
                        coll_tog_d = !coll_tog_q;
                    end
                    // Echo matches: hold grant and keep sending
                end
            end
            default: state_d = LINK_MONITOR;
        endcase
        if (lin.frame_sync && state_q != LINK_SEND)
        begin
            sent_one_d = 1'b0;
        end
        send_flag_d = (state_d == LINK_SEND);
    end

    always_ff @(posedge link_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_q <= LINK_MONITOR;
            ones_q <= 4'h0;
            grant_q <= 1'b0;
            sent_one_q <= 1'b0;
            loop_q <= 1'b1;
            coll_tog_q <= 1'b0;
            send_flag_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            ones_q <= ones_d;
            grant_q <= grant_d;
            sent_one_q <= sent_one_d;
            loop_q <= loop_d;
            coll_tog_q <= coll_tog_d;
            send_flag_q <= send_flag_d;
        end
    end

    // Loop idles at one, the recessive level
    assign access_grant_out_o = grant_q;
    assign loop_d_bit_o = loop_q;
endmodule

// File: tb/arb_properties.sv
`timescale 1ns/100ps
module arb_properties
#(
    parameter int ADDR_W = 8
)
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic link_clk_i,
    input wire logic d_slot_i,
    input wire logic echo_slot_i,
    input wire logic echo_bit_i,
    input wire logic interchip_serial_data_in_i,
    input wire logic access_request_in_i,
    input wire logic access_grant_out_o,
    input wire logic loop_d_bit_o
);
    // Zero echo against a one on the loop: busy or lost
    a_zero_busy: assert property (@(posedge link_clk_i) disable iff (reset_i)
        echo_slot_i && !echo_bit_i && loop_d_bit_o |=> !access_grant_out_o)
        else $error("grant kept on zero echo");
    a_lost_quiet: assert property (@(posedge link_clk_i) disable iff (reset_i)
        echo_slot_i && !echo_bit_i && loop_d_bit_o |=> loop_d_bit_o [*8])
        else $error("sending after collision");
    a_match_keeps: assert property (@(posedge link_clk_i) disable iff (reset_i)
        access_grant_out_o && echo_slot_i && echo_bit_i == loop_d_bit_o
        |=> access_grant_out_o)
        else $error("grant lost on match");
    a_grant_cause: assert property (@(posedge link_clk_i) disable iff (reset_i)
        $rose(access_grant_out_o) |-> $past(echo_slot_i) && $past(echo_bit_i))
        else $error("grant rose without echo one");
    // A loop zero only comes from a slot zero while granted
    a_copy_zero: assert property (@(posedge link_clk_i) disable iff (reset_i)
        $fell(loop_d_bit_o)
        |-> $past(d_slot_i) && !$past(interchip_serial_data_in_i)
            && $past(access_grant_out_o))
        else $error("loop zero without data zero");
    a_idle_ones: assert property (@(posedge link_clk_i) disable iff (reset_i)
        !access_request_in_i [*8] |-> loop_d_bit_o)
        else $error("forwarding without request");
    a_ready_pulse: assert property (@(posedge core_clk_i) disable iff (reset_i)
        pready_o |=> !pready_o)
        else $error("ready held");
    a_unmapped_err: assert property (@(posedge core_clk_i) disable iff (reset_i)
        pready_o && paddr_i[ADDR_W-1:4] != '0 |-> pslverr_o)
        else $error("unmapped access accepted");
    c_grant: cover property (@(posedge link_clk_i) $rose(access_grant_out_o));
    c_lost: cover property (@(posedge link_clk_i) echo_slot_i && !echo_bit_i && loop_d_bit_o);
    c_apb_err: cover property (@(posedge core_clk_i) pready_o && pslverr_o);
endmodule
bind d_channel_access_arbiter arb_properties #(.ADDR_W(ADDR_W)) arb_properties_i (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .paddr_i(paddr_i),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .link_clk_i(link_clk_i),
    .d_slot_i(d_slot_i),
    .echo_slot_i(echo_slot_i),
    .echo_bit_i(echo_bit_i),
    .interchip_serial_data_in_i(interchip_serial_data_in_i),
    .access_request_in_i(access_request_in_i),
    .access_grant_out_o(access_grant_out_o),
    .loop_d_bit_o(loop_d_bit_o)
);

// File: tb/loop_partner.sv
`timescale 1ns/100ps
module loop_partner
(
    input wire logic link_clk_i,
    input wire logic req_i,
    input wire logic loop_bit_i,
    input wire logic nt_zero_i,
    input wire logic rival_on_i,
    input wire logic [7:0] own_i,
    input wire logic [7:0] rival_i,
    output logic frame_o,
    output logic slot_o,
    output logic echo_slot_o,
    output logic echo_o,
    output logic data_o
);
    logic [2:0] pos_q = 3'h0;
    logic [2:0] bit_q = 3'h0;
    // Eight-bit frame; lines toggle outside their slots so stale bits look wrong
    always @(posedge link_clk_i)
    begin
        pos_q <= pos_q + 3'h1;
        frame_o <= pos_q == 3'h7;
        slot_o <= pos_q == 3'h1 && req_i;
        echo_slot_o <= pos_q == 3'h4;
        data_o <= pos_q == 3'h1 ? own_i[bit_q] : !data_o;
        // The rival terminal only sends while the request is up, like ours
        echo_o <= pos_q == 3'h4
            ? loop_bit_i & !nt_zero_i & (!rival_on_i | !req_i | rival_i[bit_q])
            : !echo_o;
        if (pos_q == 3'h4)
            bit_q <= req_i ? bit_q + 3'h1 : 3'h0;
    end
endmodule

// File: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
    import d_access_pkg::*;
    logic core_clk_i = 1'b0;
    logic link_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic access_request_in_i = 1'b0;
    logic nt_zero = 1'b0;
    logic rival_on = 1'b0;
    logic [7:0] own = 8'h00;
    logic [7:0] rival = 8'h00;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, frame_sync_i, d_slot_i, echo_slot_i, echo_bit_i;
    logic interchip_serial_data_in_i, access_grant_out_o, loop_d_bit_o;
    logic [32:0] apb_q[$];
    logic loop_q[$];
    int miscompares = 0;
    int checks = 0;
    int seed;
    logic [1:0] cls;

    d_channel_access_arbiter d_channel_access_arbiter_i (.core_clk_i(core_clk_i),
        .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .link_clk_i(link_clk_i), .frame_sync_i(frame_sync_i),
        .d_slot_i(d_slot_i), .echo_slot_i(echo_slot_i), .echo_bit_i(echo_bit_i),
        .interchip_serial_data_in_i(interchip_serial_data_in_i),
        .access_request_in_i(access_request_in_i),
        .access_grant_out_o(access_grant_out_o), .loop_d_bit_o(loop_d_bit_o));
    loop_partner loop_partner_i (.link_clk_i(link_clk_i), .req_i(access_request_in_i),
        .loop_bit_i(loop_d_bit_o), .nt_zero_i(nt_zero), .rival_on_i(rival_on), .own_i(own),
        .rival_i(rival), .frame_o(frame_sync_i), .slot_o(d_slot_i), .echo_slot_o(echo_slot_i),
        .echo_o(echo_bit_i), .data_o(interchip_serial_data_in_i));

    // Core clock
    always #2 core_clk_i = !core_clk_i;
    // Link clock, offset so its edges never meet the core edges
    initial
    begin
        #1.3;
        forever #40 link_clk_i = !link_clk_i;
    end

    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One APB transfer; the answer is judged by the monitor
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic [32:0] exp);
        apb_q.push_back(exp);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do @(posedge core_clk_i); while (pready_o !== 1'b1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic frames(input int n);
        repeat (n * 8) @(posedge link_clk_i);
    endtask
    // Bounded wait: a lost grant must not hang the run
    task automatic grant_is(input logic v);
        for (int n = 0; n < 300 && access_grant_out_o !== v; n++)
            @(posedge link_clk_i);
        chk({32'h0, access_grant_out_o}, {32'h0, v});
    endtask
    task automatic final_report();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // APB answers against the oldest note
    always @(posedge core_clk_i)
        if (pready_o === 1'b1 && psel_i && penable_i)
            chk({pslverr_o, pwrite_i ? 32'h0 : prdata_o}, apb_q.pop_front());
    // Loop bits against the oldest note at each echo slot while the request is up
    always @(posedge link_clk_i)
        if (echo_slot_i && access_request_in_i && loop_q.size() > 0)
            chk({32'h0, loop_d_bit_o}, {32'h0, loop_q.pop_front()});

    // Main sequence: registers, busy, win, collision, clean win
    initial
    begin
        seed = $urandom(52997);
        repeat (8) @(posedge core_clk_i);
        repeat (2) @(posedge link_clk_i);
        @(posedge core_clk_i);
        reset_i <= 1'b0;
        cls = 2'($urandom % 4);
        apb(1'b0, CTRL_OFFSET, 32'h0, {1'b0, CTRL_RESET});
        apb(1'b1, CTRL_OFFSET, {30'h1, cls}, 33'h0);
        apb(1'b0, CTRL_OFFSET, 32'h0, {1'b0, 30'h1, cls});
        apb(1'b1, STATUS_OFFSET, 32'h0, {1'b1, 32'h0});
        apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
        grant_is(1'b1);
        nt_zero <= 1'b1;
        frames(2);
        chk({32'h0, access_grant_out_o}, 33'h0);
        @(posedge link_clk_i iff echo_slot_i);
        access_request_in_i <= 1'b1;
        nt_zero <= 1'b0;
        own <= 8'($urandom);
        grant_is(1'b1);
        frames(4);
        access_request_in_i <= 1'b0;
        own <= 8'hf5;
        rival <= 8'hf1;
        rival_on <= 1'b1;
        frames(2);
        @(posedge link_clk_i iff echo_slot_i);
        access_request_in_i <= 1'b1;
        frames(5);
        chk({32'h0, access_grant_out_o}, 33'h0);
        apb(1'b0, COLL_OFFSET, 32'h0, 33'h1);
        access_request_in_i <= 1'b0;
        rival_on <= 1'b0;
        grant_is(1'b1);
        own <= 8'hf1;
        rival <= 8'hf5;
        rival_on <= 1'b1;
        for (int i = 0; i < 8; i++)
            loop_q.push_back(1'((8'hf1 >> i) & 8'h01));
        @(posedge link_clk_i iff echo_slot_i);
        access_request_in_i <= 1'b1;
        frames(9);
        chk({32'h0, access_grant_out_o}, 33'h1);
        chk({32'h0, 32'(loop_q.size())}, 33'h0);
        apb(1'b0, STATUS_OFFSET, 32'h0, 33'h3);
        final_report();
    end
    // Watchdog, sized well above the expected run
    initial
    begin
        #150us;
        miscompares++;
        final_report();
    end
endmodule
